// [smr_regs.svh]
// register offsets, field positions, reset values and counts for the supply monitor
`ifndef SMR_REGS_SVH
`define SMR_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SMR_ADDR_STATUS   4'h0
`define SMR_ADDR_MASK     4'h4
`define SMR_ADDR_CTRL     4'h8
`define SMR_ADDR_LEVEL    4'hC

// ----------------------------------------
// field positions
// ----------------------------------------
`define SMR_BIT_BOR_FLAG  0
`define SMR_BIT_WARN_EVT  1
`define SMR_BIT_WARN_EN   0
`define SMR_BIT_LIVE_WARN 0
`define SMR_BIT_LIVE_BOR  1

// ----------------------------------------
// reset values
// ----------------------------------------
`define SMR_RST_STATUS    2'h0
`define SMR_RST_MASK      2'h0
`define SMR_RST_CTRL      1'h0

// ----------------------------------------
// comparator ladder and reset delay
// ----------------------------------------
`define SMR_TAPS          9
`define SMR_WARN_OFFSET   4'h3
`define SMR_DLY_SHORT_CYC 256
`define SMR_DLY_LONG_CYC  4096
`define SMR_DLY_SHORT     12'(`SMR_DLY_SHORT_CYC - 1)
`define SMR_DLY_LONG      12'(`SMR_DLY_LONG_CYC - 1)

`endif

// [smr_pkg.sv]
// types shared by the supply monitor and reset block
package smr_pkg;

	// option settings from nonvolatile storage
	typedef struct packed {
		logic       borEnable;
		logic [1:0] borLevel;
		logic       longDelay;
	} smr_opt_t;

	// sticky event bits, same layout for status and mask
	typedef struct packed {
		logic warnEvent;
		logic borFlag;
	} smr_evt_t;

	typedef enum logic [2:0] {
		SMR_HOLD  = 3'h1,
		SMR_DELAY = 3'h2,
		SMR_RUN   = 3'h4
	} smr_state_t;

endpackage

// [smr_supply_monitor_reset.sv]
// supply supervisor: brownout reset, reset delay and supply warning interrupt
// Operation
// - hold internal reset while brownout low
// - falling threshold below rising threshold
// - brownout sets sticky hardware flag
// - drive external reset pin low during brownout
// - three selectable brownout levels from options
// - brownout optional, disabled means no reset
// - warning interrupt on every fall, and on every rise outside the reset delay
// - read-only live warning status bit
// - warning threshold sits above brownout threshold
// - no rise interrupt within reset delay
// - enabling below threshold gives two interrupts
// - enabling above threshold gives no interrupt
`timescale 1ns/1ps
`include "smr_regs.svh"

module smr_supply_monitor_reset
	import smr_pkg::*;
(
	input  wire logic                     mclk,
	input  wire logic                     rst_b,
	input  wire logic [`SMR_TAPS-1:0]     supplyAbove,
	input  wire logic                     optBorEnable,
	input  wire logic [1:0]               optBorLevel,
	input  wire logic                     optLongDelay,
	input  wire logic [3:0]               address,
	input  wire logic                     read,
	input  wire logic                     write,
	input  wire logic [31:0]              writedata,
	output logic      [31:0]              readdata,
	output logic                          waitrequest,
	output logic                          coreReset,
	output logic                          externalResetPinOut,
	output logic                          externalResetPinOe,
	output logic                          irq
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [`SMR_TAPS-1:0] aboveMeta_q;
	logic [`SMR_TAPS-1:0] aboveSync_q;
	smr_opt_t             optMeta_q;
	smr_opt_t             opt_q;

	// option bits reset to zero, so brownout stays off until the options settle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			aboveMeta_q <= '0;
			aboveSync_q <= '0;
			optMeta_q   <= '0;
			opt_q       <= '0;
		end else begin
			aboveMeta_q <= supplyAbove;
			aboveSync_q <= aboveMeta_q;
			optMeta_q   <= '{optBorEnable, optBorLevel, optLongDelay};
			opt_q       <= optMeta_q;
		end
	end

	a_sync_depth: assert property (@(posedge mclk) disable iff (!rst_b)
		$past(rst_b, 3) |-> aboveSync_q == $past(supplyAbove, 2))
		else $error("comparator inputs not delayed by two stages");

	// ----------------------------------------
	// threshold selection
	// ----------------------------------------
	// level 3 is not a legal option and falls back to high
	logic [1:0] levelSel;
	logic [3:0] borFallTap;
	logic [3:0] borRiseTap;
	logic [3:0] warnFallTap;
	logic [3:0] warnRiseTap;

	always_comb begin
		levelSel    = (opt_q.borLevel == 2'h3) ? 2'h2 : opt_q.borLevel;
		borFallTap  = {1'b0, levelSel, 1'b0};
		borRiseTap  = borFallTap + 4'h1;
		warnFallTap = borFallTap + `SMR_WARN_OFFSET;
		warnRiseTap = warnFallTap + 4'h1;
	end

	a_level_taps: assert property (@(posedge mclk) disable iff (!rst_b)
		warnFallTap > borRiseTap && borFallTap <= 4'h4)
		else $error("threshold taps out of order");

	// ----------------------------------------
	// hysteresis on both comparators
	// ----------------------------------------
	logic borActive_q;
	logic warnActive_q;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			borActive_q <= 1'b1;
		end else if (borActive_q) begin
			borActive_q <= !aboveSync_q[borRiseTap];
		end else begin
			borActive_q <= !aboveSync_q[borFallTap];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			warnActive_q <= 1'b1;
		end else if (warnActive_q) begin
			warnActive_q <= !aboveSync_q[warnRiseTap];
		end else begin
			warnActive_q <= !aboveSync_q[warnFallTap];
		end
	end

	a_bor_hyst: assert property (@(posedge mclk) disable iff (!rst_b)
		$fell(borActive_q) |-> $past(aboveSync_q[borRiseTap]))
		else $error("brownout released below rising threshold");

	a_bor_enter: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(borActive_q) |-> !$past(aboveSync_q[borFallTap]))
		else $error("brownout entered above falling threshold");

	a_warn_enter: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(warnActive_q) |-> !$past(aboveSync_q[warnFallTap]))
		else $error("warning entered above warning threshold");

	// ----------------------------------------
	// reset sequencer
	// ----------------------------------------
	smr_state_t state_q;
	logic [11:0] delayCnt_q;
	logic        borLow;

	assign borLow = borActive_q && opt_q.borEnable;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= SMR_HOLD;
		end else begin
			case (state_q)
				SMR_HOLD: begin
					if (!borLow) begin
						state_q <= SMR_DELAY;
					end
				end
				SMR_DELAY: begin
					if (borLow) begin
						state_q <= SMR_HOLD;
					end else if (delayCnt_q == 12'h000) begin
						state_q <= SMR_RUN;
					end
				end
				SMR_RUN: begin
					if (borLow) begin
						state_q <= SMR_HOLD;
					end
				end
				default: begin
					state_q <= SMR_HOLD;
				end
			endcase
		end
	end

	// reload on every hold so the delay always restarts in full
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			delayCnt_q <= `SMR_DLY_LONG;
		end else if (state_q != SMR_DELAY) begin
			delayCnt_q <= opt_q.longDelay ? `SMR_DLY_LONG : `SMR_DLY_SHORT;
		end else if (delayCnt_q != 12'h000) begin
			delayCnt_q <= delayCnt_q - 12'h001;
		end
	end

	logic resetBusy;
	assign resetBusy = (state_q != SMR_RUN);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			coreReset           <= 1'b1;
			externalResetPinOut <= 1'b0;
			externalResetPinOe  <= 1'b1;
		end else begin
			coreReset           <= resetBusy || borLow;
			externalResetPinOut <= 1'b0;
			externalResetPinOe  <= resetBusy || borLow;
		end
	end

	a_reset_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		borLow |=> coreReset)
		else $error("core left running during brownout");

	a_pin_low: assert property (@(posedge mclk) disable iff (!rst_b)
		borLow |=> externalResetPinOe && !externalResetPinOut)
		else $error("external reset pin not driven low in brownout");

	a_bor_disabled: assert property (@(posedge mclk) disable iff (!rst_b)
		(state_q == SMR_RUN) && !opt_q.borEnable |=> state_q == SMR_RUN)
		else $error("brownout reset while function disabled");

	a_delay_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		state_q != SMR_RUN |=> coreReset && externalResetPinOe)
		else $error("reset released before delay ended");

	// ----------------------------------------
	// warning events
	// ----------------------------------------
	logic warnEnable_q;
	logic warnEnPrev_q;
	logic warnPrev_q;
	logic warnFall;
	logic warnRise;
	logic enableArm;
	smr_evt_t evtSet;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			warnPrev_q   <= 1'b1;
			warnEnPrev_q <= 1'b0;
		end else begin
			warnPrev_q   <= warnActive_q;
			warnEnPrev_q <= warnEnable_q;
		end
	end

	// a rise seen while the reset delay runs is dropped on purpose
	always_comb begin
		warnFall  = warnActive_q && !warnPrev_q;
		warnRise  = !warnActive_q && warnPrev_q && !resetBusy;
		enableArm = warnEnable_q && !warnEnPrev_q && warnActive_q;
		evtSet.borFlag   = borLow;
		evtSet.warnEvent = warnEnable_q && (warnFall || warnRise || enableArm);
	end

	a_rise_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
		resetBusy && !warnActive_q |-> !evtSet.warnEvent)
		else $error("warning event raised during reset delay");

	a_enable_above: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(warnEnable_q) && !warnActive_q && $stable(warnActive_q) |-> !evtSet.warnEvent)
		else $error("extra warning event when enabled above threshold");

	a_warn_off: assert property (@(posedge mclk) disable iff (!rst_b)
		!warnEnable_q |-> !evtSet.warnEvent)
		else $error("warning event while interrupt disabled");

	a_warn_fall: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(warnActive_q) && warnEnable_q |=> status_q.warnEvent)
		else $error("falling crossing raised no warning event");

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	smr_evt_t status_q;
	smr_evt_t mask_q;
	logic     ack_q;
	logic     wrTake;
	logic     rdTake;
	smr_evt_t w1c;

	// one wait state: a write is taken on the second edge after it rises, read data is captured on the first
	assign waitrequest = (read || write) && !ack_q;
	assign wrTake      = write && ack_q;
	assign rdTake      = read && !ack_q;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (read || write) && !ack_q;
		end
	end

	always_comb begin
		w1c = '0;
		if (wrTake && address == `SMR_ADDR_STATUS) begin
			w1c = smr_evt_t'(writedata[1:0]);
		end
	end

	// a new event beats a clear landing in the same cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			status_q <= `SMR_RST_STATUS;
		end else begin
			status_q <= (status_q & ~w1c) | evtSet;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mask_q       <= `SMR_RST_MASK;
			warnEnable_q <= `SMR_RST_CTRL;
		end else if (wrTake && address == `SMR_ADDR_MASK) begin
			mask_q <= smr_evt_t'(writedata[1:0]);
		end else if (wrTake && address == `SMR_ADDR_CTRL) begin
			warnEnable_q <= writedata[`SMR_BIT_WARN_EN];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			readdata <= '0;
		end else if (rdTake) begin
			if (address == `SMR_ADDR_STATUS) begin
				readdata <= {30'h0, status_q};
			end else if (address == `SMR_ADDR_MASK) begin
				readdata <= {30'h0, mask_q};
			end else if (address == `SMR_ADDR_CTRL) begin
				readdata <= {31'h0, warnEnable_q};
			end else if (address == `SMR_ADDR_LEVEL) begin
				readdata <= {30'h0, borActive_q, warnActive_q};
			end else begin
				readdata <= '0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_q & mask_q);
		end
	end

	a_flag_set: assert property (@(posedge mclk) disable iff (!rst_b)
		borLow |=> status_q.borFlag)
		else $error("brownout flag not set");

	a_warn_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
		evtSet.warnEvent |=> status_q.warnEvent ##1 (status_q.warnEvent || $past(wrTake)))
		else $error("warning event lost");

	a_live_status: assert property (@(posedge mclk) disable iff (!rst_b)
		rdTake && address == `SMR_ADDR_LEVEL |=> readdata[0] == $past(warnActive_q) && !waitrequest)
		else $error("live warning bit misread");

	a_irq_level: assert property (@(posedge mclk) disable iff (!rst_b)
		irq == $past(|(status_q & mask_q)))
		else $error("interrupt line does not follow masked status");

endmodule

// [tb_supply_monitor_reset.sv]
// self-checking testbench for the supply monitor and reset block
`timescale 1ns/1ps
`include "smr_regs.svh"

module tb_supply_monitor_reset;
	logic        mclk = 1'h0;
	logic        rst_b = 1'h0;
	logic [8:0]  sup = 9'h1FF;
	logic        bEn = 1'h1;
	logic [1:0]  lvl = 2'h0;
	logic        lDly = 1'h0;
	logic [3:0]  adr = 4'h0;
	logic        rd = 1'h0;
	logic        wr = 1'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic [31:0] v;
	logic        wreq;
	logic        cRst;
	logic        pOut;
	logic        pOe;
	logic        irq;
	int          n_errors = 0;
	int          compares = 0;

	always #50 mclk = ~mclk;

	smr_supply_monitor_reset dut_u (
		.mclk                (mclk),
		.rst_b               (rst_b),
		.supplyAbove         (sup),
		.optBorEnable        (bEn),
		.optBorLevel         (lvl),
		.optLongDelay        (lDly),
		.address             (adr),
		.read                (rd),
		.write               (wr),
		.writedata           (wd),
		.readdata            (rdat),
		.waitrequest         (wreq),
		.coreReset           (cRst),
		.externalResetPinOut (pOut),
		.externalResetPinOe  (pOe),
		.irq                 (irq)
	);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask

	// waitrequest is sampled just before the edge, which is its value at that edge
	task automatic waitAck();
		int   n;
		logic w;
		n = 0;
		do begin
			@(negedge mclk);
			w = wreq;
			@(posedge mclk);
			n++;
		end while (w !== 1'h0 && n < 20);
		if (n >= 20) begin
			n_errors++;
			$display("BAD waitrequest exp 0 seen 1");
		end
	endtask

	task automatic busWr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		adr <= a;
		wd <= d;
		wr <= 1'h1;
		waitAck();
		wr <= 1'h0;
	endtask

	task automatic busRd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		adr <= a;
		rd <= 1'h1;
		waitAck();
		d = rdat;
		rd <= 1'h0;
	endtask

	task automatic waitRst(input logic e, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (cRst !== e && n < lim);
		chk("coreReset", {31'h0, cRst}, {31'h0, e});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic supTo(input logic [8:0] s);
		@(posedge mclk);
		sup <= s;
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge mclk);
		rst_b <= 1'h1;
		cyc(4);
		chk("pinOe", {31'h0, pOe}, 32'h1);
		busRd(`SMR_ADDR_MASK, v);
		chk("mask", v, 32'h0);
		busRd(`SMR_ADDR_CTRL, v);
		chk("ctrl", v, 32'h0);
		busRd(4'h2, v);
		chk("unmapped", v, 32'h0);
		waitRst(1'h0, 400);
		busWr(`SMR_ADDR_STATUS, 32'h3);
		busRd(`SMR_ADDR_STATUS, v);
		chk("status", v, 32'h0);
		$display("test reset done");
		// brownout at the low level, with hysteresis between fall and rise taps
		@(posedge mclk);
		sup <= 9'h000;
		cyc(2);
		chk("coreReset", {31'h0, cRst}, 32'h0);
		cyc(3);
		chk("coreReset", {31'h0, cRst}, 32'h1);
		chk("pin", {30'h0, pOe, pOut}, 32'h2);
		supTo(9'h001);
		cyc(300);
		chk("coreReset", {31'h0, cRst}, 32'h1);
		busRd(`SMR_ADDR_LEVEL, v);
		chk("level", v & 32'h2, 32'h2);
		sup <= 9'h1FF;
		waitRst(1'h0, 400);
		chk("pinOe", {31'h0, pOe}, 32'h0);
		busRd(`SMR_ADDR_STATUS, v);
		chk("status", v & 32'h1, 32'h1);
		busWr(`SMR_ADDR_STATUS, 32'h3);
		$display("test brownout done");
		// medium, high, and the spare code that acts as high: fall tap is 2k, k being the level after fallback
		for (int l = 1; l < 4; l++) begin
			int k;
			k = (l > 2) ? 2 : l;
			@(posedge mclk);
			lvl <= 2'(l);
			sup <= 9'((1 << (2 * k + 1)) - 1);
			cyc(10);
			chk("coreReset", {31'h0, cRst}, 32'h0);
			supTo(9'((1 << (2 * k)) - 1));
			cyc(6);
			chk("coreReset", {31'h0, cRst}, 32'h1);
			supTo(9'h1FF);
			waitRst(1'h0, 400);
		end
		@(posedge mclk);
		lvl <= 2'h0;
		bEn <= 1'h0;
		sup <= 9'h000;
		cyc(10);
		chk("coreReset", {31'h0, cRst}, 32'h0);
		supTo(9'h1FF);
		cyc(6);
		// re-enable only once the comparator has settled, else a stale low reading resets
		@(posedge mclk);
		bEn <= 1'h1;
		cyc(6);
		busWr(`SMR_ADDR_STATUS, 32'h3);
		$display("test levels done");
		// warning crossings in both directions
		busWr(`SMR_ADDR_MASK, 32'h2);
		busWr(`SMR_ADDR_CTRL, 32'h1);
		sup <= 9'h007;
		cyc(6);
		chk("irq", {31'h0, irq}, 32'h1);
		chk("coreReset", {31'h0, cRst}, 32'h0);
		busWr(`SMR_ADDR_LEVEL, 32'h0);
		busRd(`SMR_ADDR_LEVEL, v);
		chk("level", v, 32'h1);
		busWr(`SMR_ADDR_STATUS, 32'h2);
		cyc(3);
		chk("irq", {31'h0, irq}, 32'h0);
		supTo(9'h1FF);
		cyc(6);
		chk("irq", {31'h0, irq}, 32'h1);
		busWr(`SMR_ADDR_STATUS, 32'h2);
		// enable while below the warning threshold: event at enable and at rise
		busWr(`SMR_ADDR_CTRL, 32'h0);
		sup <= 9'h007;
		cyc(6);
		busWr(`SMR_ADDR_CTRL, 32'h1);
		cyc(3);
		busRd(`SMR_ADDR_STATUS, v);
		chk("status", v, 32'h2);
		busWr(`SMR_ADDR_STATUS, 32'h2);
		sup <= 9'h1FF;
		cyc(6);
		busRd(`SMR_ADDR_STATUS, v);
		chk("status", v, 32'h2);
		busWr(`SMR_ADDR_STATUS, 32'h2);
		// enable only after the rise: no further event
		busWr(`SMR_ADDR_CTRL, 32'h0);
		sup <= 9'h007;
		cyc(6);
		supTo(9'h1FF);
		cyc(6);
		busWr(`SMR_ADDR_CTRL, 32'h1);
		cyc(3);
		busRd(`SMR_ADDR_STATUS, v);
		chk("status", v, 32'h0);
		$display("test warning done");
		// fast rise inside the long reset delay gives no rise event
		@(posedge mclk);
		lDly <= 1'h1;
		sup <= 9'h000;
		cyc(6);
		supTo(9'h1FF);
		cyc(6);
		busWr(`SMR_ADDR_STATUS, 32'h3);
		cyc(3900);
		chk("coreReset", {31'h0, cRst}, 32'h1);
		waitRst(1'h0, 400);
		cyc(3);
		busRd(`SMR_ADDR_STATUS, v);
		chk("status", v, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		$display("test delay done");
		stop_test();
	end

	// the tests need about 6000 cycles
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		stop_test();
	end
endmodule
